/* File: hw/wake_pkg.sv */
// constants, register map and timing figures for the wake clock mask block
// assumes a single 25 MHz reference clock shared by every user of the package
package wake_pkg;
   localparam int unsigned CLK_PERIOD_NS    = 40;
   localparam int unsigned TIMER_W          = 12;

   // times in their own unit, cycle counts derived from the clock period
   localparam int unsigned OVERSHOOT_NS     = 6000;
   localparam int unsigned HOLD_LONG_NS     = 150000;
   localparam int unsigned HOLD_SHORT_NS    = 2000;
   localparam int unsigned SETTLE_FP_NS     = 2000;
   localparam int unsigned SETTLE_NORMAL_NS = 150000;

   // longest time: round down
   localparam int unsigned OVERSHOOT_CYC    = OVERSHOOT_NS / CLK_PERIOD_NS;
   // least times: round up
   localparam int unsigned HOLD_LONG_CYC    = (HOLD_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_SHORT_CYC   = (HOLD_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_FP_CYC    = (SETTLE_FP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_NORM_CYC  =
      (SETTLE_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // per core level thresholds of the tunable oscillator, in kHz
   localparam logic [15:0] FAST_KHZ_L0      = 16'h1388;
   localparam logic [15:0] FAST_KHZ_L1      = 16'h1D4C;
   localparam logic [15:0] FAST_KHZ_L2      = 16'h2710;
   localparam logic [15:0] FAST_KHZ_L3      = 16'h30D4;

   // sleep depths
   localparam logic [2:0]  DEPTH_THREE      = 3'h3;
   localparam logic [2:0]  DEPTH_FOUR       = 3'h4;

   // register byte offsets
   localparam logic [3:0]  OFS_SUPPLY_CTRL  = 4'h0;
   localparam logic [3:0]  OFS_CLOCK_CTRL   = 4'h4;
   localparam logic [3:0]  OFS_STATUS       = 4'h8;

   // supply control fields
   localparam int unsigned B_SUP_EN         = 0;
   localparam int unsigned B_MON_EN         = 1;
   localparam int unsigned B_SUP_FP         = 2;
   localparam int unsigned B_MON_FP         = 3;
   localparam int unsigned B_LEVEL_LO       = 4;
   localparam int unsigned B_LEVEL_HI       = 5;
   localparam logic [5:0]  SUPPLY_RESET     = 6'h03;

   // clock control fields
   localparam int unsigned B_DIV_LO         = 0;
   localparam int unsigned B_DIV_HI         = 2;
   localparam int unsigned B_SRC_XTAL       = 3;
   localparam int unsigned B_REQ_EN         = 4;
   localparam logic [4:0]  CLOCK_RESET      = 5'h10;

   // status fields
   localparam int unsigned B_ST_HOLD        = 0;
   localparam int unsigned B_ST_OVER        = 1;
   localparam int unsigned B_ST_SETTLE      = 2;
   localparam int unsigned B_ST_RESET       = 3;

   localparam logic [2:0]  DIV_MAX          = 3'h5;
endpackage : wake_pkg

/* File: hw/countdown_if.sv */
// start and busy signals between the wake block and its countdown timers
// assumes both ends on the same reference clock
`timescale 1ns/1ps
`default_nettype none
interface countdown_if #(parameter int W = 12);
   logic         start;
   logic [W-1:0] load;
   logic         busy;
   logic         done;
   modport timer (input start, input load, output busy, output done);
   modport user  (output start, output load, input busy, input done);
endinterface : countdown_if
`default_nettype wire

/* File: hw/countdown_timer.sv */
// reloadable down counter: busy for exactly load cycles after start
// assumes start is a one-cycle pulse on the same clock
`timescale 1ns/1ps
`default_nettype none
module countdown_timer #(
   parameter int W = 12
) (
   input  wire logic  ref_clk,
   input  wire logic  rst,
   countdown_if.timer t
);
   logic [W-1:0] cnt_reg;
   logic         done_reg;

   // a start while running reloads, so a repeated wake restarts the wait
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (t.start) begin
         cnt_reg <= t.load;
      end else if (cnt_reg != '0) begin
         cnt_reg <= cnt_reg - W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (cnt_reg == W'(1)) && !t.start;
      end
   end

   assign t.busy = (cnt_reg != '0);
   assign t.done = done_reg;
endmodule : countdown_timer
`default_nettype wire

/* File: hw/lowpower_wake_clock_mask.sv */
// wake hold-off, oscillator overshoot window and core level settle supervision
// assumes sleep_active comes from logic on ref_clk; vcore_ok is an analog, asynchronous level
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - tunable oscillator may overshoot for up to 6 us after deep sleep exit
// - normal-performance supervisor and monitor hold the cpu 150 us after wake
// - off or full-performance supervision with fast tunable main clock shortens hold to 2 us
// - short case when both enables are 0 or both full-performance bits 1
// - subsystem clock from tunable oscillator is not masked during overshoot
// - full-performance supervision uses a settling delay of about 2 us
// - core level raise in full-performance mode resets device if voltage unsettled
// - normal mode supervision settles for about 150 us after a level raise
module lowpower_wake_clock_mask (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        sleep_active,
   input  wire logic [2:0]  sleep_depth,
   input  wire logic        mclk_from_tunable,
   input  wire logic [15:0] tunable_freq_khz,
   input  wire logic        vcore_ok,
   output logic             cpu_hold,
   output logic             cpu_clk_en,
   output logic             osc_overshoot,
   output logic             subsys_clk_en,
   output logic             subsys_from_xtal,
   output logic             subsys_fast,
   output logic      [2:0]  main_clock_divider,
   output logic             core_reset
);
   localparam int W = wake_pkg::TIMER_W;

   logic [5:0]  supply_reg;
   logic [4:0]  clock_reg;
   logic        reset_flag_reg;
   logic [31:0] rdata_reg;
   logic        sleep_prev_reg;
   logic [2:0]  depth_reg;
   logic        vcore_meta_reg;
   logic        vcore_sync_reg;
   logic        core_reset_reg;
   logic [4:0]  div_cnt_reg;
   logic        wake_exit;
   logic        short_hold;
   logic        level_raise;
   logic        wr_supply;

   countdown_if #(.W(W)) over_t ();
   countdown_if #(.W(W)) hold_t ();
   countdown_if #(.W(W)) settle_t ();

   countdown_timer #(.W(W)) u_over   (.ref_clk(ref_clk), .rst(rst), .t(over_t));
   countdown_timer #(.W(W)) u_hold   (.ref_clk(ref_clk), .rst(rst), .t(hold_t));
   countdown_timer #(.W(W)) u_settle (.ref_clk(ref_clk), .rst(rst), .t(settle_t));

   function automatic logic [15:0] fast_limit(input logic [1:0] level);
      case (level)
         2'h0:    fast_limit = wake_pkg::FAST_KHZ_L0;
         2'h1:    fast_limit = wake_pkg::FAST_KHZ_L1;
         2'h2:    fast_limit = wake_pkg::FAST_KHZ_L2;
         default: fast_limit = wake_pkg::FAST_KHZ_L3;
      endcase
   endfunction : fast_limit

   function automatic logic [4:0] div_mask(input logic [2:0] div);
      logic [2:0] d;
      d = (div > wake_pkg::DIV_MAX) ? wake_pkg::DIV_MAX : div;
      div_mask = 5'((6'h01 << d) - 6'h01);
   endfunction : div_mask

   // vcore_ok crosses from the analog side
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         vcore_meta_reg <= 1'b0;
         vcore_sync_reg <= 1'b0;
      end else begin
         vcore_meta_reg <= vcore_ok;
         vcore_sync_reg <= vcore_meta_reg;
      end
   end

   // remember how deep the sleep was, to know whether its exit counts
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sleep_prev_reg <= 1'b0;
         depth_reg      <= 3'h0;
      end else begin
         sleep_prev_reg <= sleep_active;
         if (sleep_active) begin
            depth_reg <= sleep_depth;
         end
      end
   end

   assign wake_exit = sleep_prev_reg && !sleep_active &&
                      ((depth_reg == wake_pkg::DEPTH_THREE) ||
                       (depth_reg == wake_pkg::DEPTH_FOUR));
   assign short_hold =
      ((!supply_reg[wake_pkg::B_SUP_EN] && !supply_reg[wake_pkg::B_MON_EN]) ||
       (supply_reg[wake_pkg::B_SUP_FP] && supply_reg[wake_pkg::B_MON_FP])) &&
      mclk_from_tunable &&
      (tunable_freq_khz > fast_limit(supply_reg[wake_pkg::B_LEVEL_HI:wake_pkg::B_LEVEL_LO]));
   assign over_t.start = wake_exit;
   assign over_t.load  = W'(wake_pkg::OVERSHOOT_CYC);
   assign hold_t.start = wake_exit;
   assign hold_t.load  = short_hold ? W'(wake_pkg::HOLD_SHORT_CYC) : W'(wake_pkg::HOLD_LONG_CYC);
   assign wr_supply   = reg_wr && (reg_addr == wake_pkg::OFS_SUPPLY_CTRL);
   assign level_raise = wr_supply &&
      (reg_wdata[wake_pkg::B_LEVEL_HI:wake_pkg::B_LEVEL_LO] >
       supply_reg[wake_pkg::B_LEVEL_HI:wake_pkg::B_LEVEL_LO]);
   // settle delay follows the mode being written with the raise
   assign settle_t.start = level_raise;
   assign settle_t.load  = reg_wdata[wake_pkg::B_SUP_FP] ? W'(wake_pkg::SETTLE_FP_CYC)
                                                          : W'(wake_pkg::SETTLE_NORM_CYC);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         supply_reg <= wake_pkg::SUPPLY_RESET;
      end else if (wr_supply) begin
         supply_reg <= reg_wdata[5:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         clock_reg <= wake_pkg::CLOCK_RESET;
      end else if (reg_wr && (reg_addr == wake_pkg::OFS_CLOCK_CTRL)) begin
         clock_reg <= reg_wdata[4:0];
      end
   end

   // delay ran out before the rail settled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         core_reset_reg <= 1'b0;
      end else begin
         core_reset_reg <= settle_t.done && !vcore_sync_reg;
      end
   end

   // sticky reset cause; a new event beats a write-one clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         reset_flag_reg <= 1'b0;
      end else if (core_reset_reg) begin
         reset_flag_reg <= 1'b1;
      end else if (reg_wr && (reg_addr == wake_pkg::OFS_STATUS) &&
                   reg_wdata[wake_pkg::B_ST_RESET]) begin
         reset_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_reg <= 32'h0;
      end else if (!reg_rd) begin
         rdata_reg <= 32'h0;
      end else if (reg_addr == wake_pkg::OFS_SUPPLY_CTRL) begin
         rdata_reg <= {26'h0, supply_reg};
      end else if (reg_addr == wake_pkg::OFS_CLOCK_CTRL) begin
         rdata_reg <= {27'h0, clock_reg};
      end else if (reg_addr == wake_pkg::OFS_STATUS) begin
         rdata_reg <= {28'h0, reset_flag_reg, settle_t.busy, over_t.busy, hold_t.busy};
      end else begin
         rdata_reg <= 32'h0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         div_cnt_reg <= 5'h0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 5'h01;
      end
   end

   // no fetch while the hold timer runs
   assign cpu_hold   = hold_t.busy;
   assign cpu_clk_en = !hold_t.busy &&
      ((div_cnt_reg & div_mask(clock_reg[wake_pkg::B_DIV_HI:wake_pkg::B_DIV_LO])) == 5'h00);

   // the overshoot is not masked from the subsystem clock
   assign subsys_clk_en    = clock_reg[wake_pkg::B_REQ_EN];
   assign subsys_fast      = over_t.busy && !clock_reg[wake_pkg::B_SRC_XTAL] &&
                             clock_reg[wake_pkg::B_REQ_EN];
   assign subsys_from_xtal = clock_reg[wake_pkg::B_SRC_XTAL];
   assign osc_overshoot    = over_t.busy;
   assign main_clock_divider = clock_reg[wake_pkg::B_DIV_HI:wake_pkg::B_DIV_LO];
   assign core_reset       = core_reset_reg;
   assign reg_rdata        = rdata_reg;

   // checking helpers: run length of hold and settle, and expected lengths
   localparam int OS_TAIL = wake_pkg::OVERSHOOT_CYC - 7;
   logic [W-1:0] hold_run_reg;
   logic [W-1:0] hold_exp_reg;
   logic [W-1:0] settle_run_reg;
   logic [W-1:0] settle_exp_reg;

   always_ff @(posedge ref_clk) begin
      if (rst || wake_exit) begin
         hold_run_reg <= '0;
      end else if (hold_t.busy) begin
         hold_run_reg <= hold_run_reg + W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_exp_reg <= '0;
      end else if (wake_exit) begin
         hold_exp_reg <= hold_t.load;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || level_raise) begin
         settle_run_reg <= '0;
      end else if (settle_t.busy) begin
         settle_run_reg <= settle_run_reg + W'(1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         settle_exp_reg <= '0;
      end else if (level_raise) begin
         settle_exp_reg <= settle_t.load;
      end
   end

   sequence s_over_high;
      osc_overshoot [*8];
   endsequence
   property p_hold_start;
      @(posedge ref_clk) disable iff (rst) wake_exit |=> cpu_hold;
   endproperty
   a_hold_start: assert property (p_hold_start) else $error("hold not raised on wake");
   property p_no_fetch;
      @(posedge ref_clk) disable iff (rst) cpu_hold |-> !cpu_clk_en;
   endproperty
   a_no_fetch: assert property (p_no_fetch) else $error("cpu clocked during hold");
   property p_hold_len;
      @(posedge ref_clk) disable iff (rst) $fell(cpu_hold) |-> (hold_run_reg == hold_exp_reg);
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
   property p_short_sel;
      @(posedge ref_clk) disable iff (rst)
         (wake_exit && short_hold) |=> (hold_exp_reg == W'(wake_pkg::HOLD_SHORT_CYC));
   endproperty
   a_short_sel: assert property (p_short_sel) else $error("short hold not chosen");
   property p_long_sel;
      @(posedge ref_clk) disable iff (rst)
         (wake_exit && supply_reg[wake_pkg::B_SUP_EN] && !supply_reg[wake_pkg::B_SUP_FP])
         |=> (hold_exp_reg == W'(wake_pkg::HOLD_LONG_CYC));
   endproperty
   a_long_sel: assert property (p_long_sel) else $error("long hold not chosen");
   property p_over_window;
      @(posedge ref_clk) disable iff (rst)
         wake_exit |=> s_over_high ##[OS_TAIL:OS_TAIL] (!osc_overshoot || $past(wake_exit));
   endproperty
   a_over_window: assert property (p_over_window) else $error("overshoot window wrong");
   property p_subsys_unmasked;
      @(posedge ref_clk) disable iff (rst)
         (wake_exit && !reg_wr && subsys_clk_en && !subsys_from_xtal) |=> subsys_fast;
   endproperty
   a_subsys_unmasked: assert property (p_subsys_unmasked) else $error("overshoot masked");
   property p_settle_len;
      @(posedge ref_clk) disable iff (rst)
         $fell(settle_t.busy) |-> (settle_run_reg == settle_exp_reg);
   endproperty
   a_settle_len: assert property (p_settle_len) else $error("settle length wrong");
   property p_settle_mode;
      @(posedge ref_clk) disable iff (rst)
         (level_raise && !reg_wdata[wake_pkg::B_SUP_FP])
         |=> (settle_exp_reg == W'(wake_pkg::SETTLE_NORM_CYC)) && settle_t.busy;
   endproperty
   a_settle_mode: assert property (p_settle_mode) else $error("normal settle not used");
   property p_core_reset;
      @(posedge ref_clk) disable iff (rst)
         ($fell(settle_t.busy) && !vcore_sync_reg && !level_raise) |=> core_reset ##1 reset_flag_reg;
   endproperty
   a_core_reset: assert property (p_core_reset) else $error("no reset on unsettled core");
endmodule : lowpower_wake_clock_mask
`default_nettype wire

/* File: bench/lowpower_wake_clock_mask_tb.sv */
// self-checking bench for the wake hold-off, overshoot and settle block
// assumes the register map of wake_pkg and one 25 MHz ref_clk; no partner model
`timescale 1ns/1ps
`default_nettype none
module lowpower_wake_clock_mask_tb;
   localparam int LONG_CYC  = 150000 / 40;
   localparam int SHORT_CYC = 2000 / 40;
   localparam int OVER_CYC  = 6000 / 40;
   localparam int WIN       = 3800;
   logic        ref_clk            = 1'b0;
   logic        rst                = 1'b1;
   logic [3:0]  reg_addr           = 4'h0;
   logic [31:0] reg_wdata          = 32'h0;
   logic        reg_wr             = 1'b0;
   logic        reg_rd             = 1'b0;
   logic [31:0] reg_rdata;
   logic        sleep_active       = 1'b0;
   logic [2:0]  sleep_depth        = 3'h0;
   logic        mclk_from_tunable  = 1'b1;
   logic [15:0] tunable_freq_khz   = 16'h0FA0;
   logic        vcore_ok           = 1'b1;
   logic        cpu_hold;
   logic        cpu_clk_en;
   logic        osc_overshoot;
   logic        subsys_clk_en;
   logic        subsys_from_xtal;
   logic        subsys_fast;
   logic [2:0]  main_clock_divider;
   logic        core_reset;
   logic [15:0] thr [4]            = '{16'h1388, 16'h1D4C, 16'h2710, 16'h30D4};
   logic [31:0] rd;
   int          errors             = 0;
   int          samples_checked    = 0;
   int          hold_n, over_n, fast_n, pulse_n, pulse_at, en_n;

   always #20 ref_clk = ~ref_clk;

   lowpower_wake_clock_mask uut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .sleep_active(sleep_active), .sleep_depth(sleep_depth),
      .mclk_from_tunable(mclk_from_tunable), .tunable_freq_khz(tunable_freq_khz),
      .vcore_ok(vcore_ok), .cpu_hold(cpu_hold), .cpu_clk_en(cpu_clk_en),
      .osc_overshoot(osc_overshoot), .subsys_clk_en(subsys_clk_en),
      .subsys_from_xtal(subsys_from_xtal), .subsys_fast(subsys_fast),
      .main_clock_divider(main_clock_divider), .core_reset(core_reset)
   );

   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : final_report

   task automatic check_word(input logic [31:0] exp, input logic [31:0] got, input string msg);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask : check_word

   task automatic check_count(input int exp, input int got, input string msg);
      samples_checked++;
      if (got != exp) begin
         errors++;
         $display("[FAIL] %0t %s: counted %0d expected %0d", $time, msg, got, exp);
      end
   endtask : check_count

   task automatic test_done(input string name);
      $display("test %s done, mismatches so far %0d", name, errors);
   endtask : test_done

   task automatic do_reset;
      rst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read

   // sleep a few cycles, leave, then count the wake outputs for a window
   task automatic wake(input logic [2:0] depth, input int window);
      @(posedge ref_clk);
      sleep_depth  <= depth;
      sleep_active <= 1'b1;
      repeat (4) @(posedge ref_clk);
      sleep_active <= 1'b0;
      hold_n = 0;
      over_n = 0;
      fast_n = 0;
      repeat (window) begin
         @(posedge ref_clk);
         #1;
         if (cpu_hold === 1'b1) hold_n++;
         if (osc_overshoot === 1'b1) over_n++;
         if (subsys_fast === 1'b1) fast_n++;
      end
   endtask : wake

   task automatic watch(input int window, input logic count_clk);
      pulse_n  = 0;
      pulse_at = 0;
      en_n     = 0;
      for (int i = 1; i <= window; i++) begin
         @(posedge ref_clk);
         #1;
         if (core_reset === 1'b1) pulse_at = i;
         if (core_reset === 1'b1) pulse_n++;
         if (count_clk && cpu_clk_en === 1'b1) en_n++;
      end
   endtask : watch

   // a hang would otherwise never reach the verdict
   initial begin
      #(40 * 60000);
      errors++;
      $display("[FAIL] %0t run exceeded its cycle budget", $time);
      final_report();
   end

   initial begin
      do_reset();
      reg_read(4'h0, rd); check_word(32'h3, rd, "supply ctrl after reset");
      reg_read(4'h4, rd); check_word(32'h10, rd, "clock ctrl after reset");
      reg_read(4'h8, rd); check_word(32'h0, rd, "status after reset");
      reg_write(4'hC, 32'hFFFFFFFF);
      reg_read(4'hC, rd); check_word(32'h0, rd, "unmapped read");
      reg_write(4'h8, 32'h7);
      reg_read(4'h8, rd); check_word(32'h0, rd, "status bits read only");
      test_done("registers");
      wake(3'h3, WIN); check_count(LONG_CYC, hold_n, "long hold");
      check_count(OVER_CYC, over_n, "overshoot window");
      check_count(OVER_CYC, fast_n, "subsystem clock unmasked");
      wake(3'h4, 1000);
      wake(3'h4, WIN); check_count(LONG_CYC, hold_n, "hold restarted");
      wake(3'h2, 200); check_count(0, hold_n + over_n, "shallow sleep exit");
      test_done("wake hold");
      reg_write(4'h4, 32'h18);
      wake(3'h3, 200); check_count(0, fast_n, "crystal source not fast");
      check_word(32'h1, {31'h0, subsys_from_xtal}, "crystal select");
      reg_write(4'h4, 32'h00);
      wake(3'h4, 200); check_count(0, fast_n, "request off not fast");
      check_word(32'h0, {31'h0, subsys_clk_en}, "request enable off");
      reg_write(4'h4, 32'h10);
      #1;
      check_word(32'h1, {31'h0, subsys_clk_en}, "request re-enabled after wait");
      check_word(32'h0, {31'h0, subsys_fast}, "re-enabled clock not fast");
      repeat (WIN) @(posedge ref_clk);
      test_done("subsystem clock");
      for (int d = 0; d < 4; d++) begin
         reg_write(4'h4, 32'h10 | d);
         watch(64, 1'b1);
         check_word(d, {29'h0, main_clock_divider}, "divider field");
         check_count(64 >> d, en_n, "cpu clock enable rate");
      end
      reg_write(4'h4, 32'h10);
      test_done("divider");
      vcore_ok <= 1'b0;
      reg_write(4'h0, 32'h1F);
      reg_read(4'h8, rd); check_word(32'h4, rd & 32'h4, "settling after raise");
      watch(100, 1'b0); check_count(1, pulse_n, "full perf raise resets");
      reg_read(4'h8, rd); check_word(32'h8, rd, "sticky reset flag");
      reg_write(4'h8, 32'h8);
      reg_read(4'h8, rd); check_word(32'h0, rd, "sticky flag cleared");
      reg_write(4'h0, 32'h23);
      watch(WIN, 1'b0); check_count(1, pulse_n, "normal raise settle");
      check_count(1, int'(pulse_at > 3700), "normal settle length");
      @(posedge ref_clk);
      vcore_ok <= 1'b1;
      reg_write(4'h0, 32'h33);
      watch(WIN, 1'b0); check_count(0, pulse_n, "settled raise no reset");
      test_done("core level");
      @(posedge ref_clk);
      do_reset();
      mclk_from_tunable <= 1'b1;
      for (int l = 0; l < 4; l++) begin
         reg_write(4'h0, (l << 4) | ((l < 2) ? 32'h0 : 32'hF));
         tunable_freq_khz <= thr[l] + 16'h1;
         wake((l % 2) ? 3'h4 : 3'h3, 200);
         check_count(SHORT_CYC, hold_n, "short hold per level");
      end
      @(posedge ref_clk);
      tunable_freq_khz <= thr[3];
      wake(3'h3, WIN); check_count(LONG_CYC, hold_n, "threshold not above");
      @(posedge ref_clk);
      tunable_freq_khz <= thr[3] + 16'h1;
      reg_write(4'h0, 32'h37);
      wake(3'h4, WIN); check_count(LONG_CYC, hold_n, "one full perf bit");
      reg_write(4'h0, 32'h3F);
      mclk_from_tunable <= 1'b0;
      wake(3'h3, WIN); check_count(LONG_CYC, hold_n, "main clock not tunable");
      test_done("short hold");
      final_report();
   end
endmodule : lowpower_wake_clock_mask_tb
`default_nettype wire
